// ### rtl/pin_pair_pkg.sv
// Purpose: constants for the two-pin configuration block
// Assumes: one clock, master clock equal to clk
// Notes:   register index and byte address kept apart
//
// Summary of operation
// - spare fields are plain read/write storage with no effect on the pins
// - bits 9 and 8 set pin one and pin zero direction, one is output
// - input with format zero reports the static pin level
// - input with format one reports the level decoded from the pwm waveform
// - an output always drives a static level, never a pwm waveform
// - time base codes 0..3 select 16, 64, 256, 1024 master clocks
// - pin one time base in bits 7:6, pin zero in 5:4, inputs only
// - an output drives low for data bit zero and high for one
// - data bit writes on an input pin are stored with no effect
package pin_pair_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0]  CFG_INDEX   = 8'hC1;
  localparam logic [11:0] CFG_ADDR    = {2'h0, CFG_INDEX, 2'h0};
  localparam logic [11:0] STAT_ADDR   = 12'h308;
  localparam logic [14:0] CFG_RESET   = 15'h0000;
  localparam logic        CFG_TOP_BIT = 1'b1;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int FMT_LSB = 10;
  localparam int DIR_LSB = 8;
  localparam int TB1_LSB = 6;
  localparam int TB0_LSB = 4;
  localparam int DAT_LSB = 0;

  // ---------------------------------------------------------------
  // time base lengths in master clock periods
  // ---------------------------------------------------------------
  localparam logic [10:0] TB_LEN_0 = 11'h010;
  localparam logic [10:0] TB_LEN_1 = 11'h040;
  localparam logic [10:0] TB_LEN_2 = 11'h100;
  localparam logic [10:0] TB_LEN_3 = 11'h400;

  typedef enum {SEL_CFG, SEL_STAT, SEL_NONE} reg_sel_e;

  function automatic logic [10:0] tb_len(input logic [1:0] code);
    case (code)
      2'h0:    tb_len = TB_LEN_0;
      2'h1:    tb_len = TB_LEN_1;
      2'h2:    tb_len = TB_LEN_2;
      default: tb_len = TB_LEN_3;
    endcase
  endfunction

  function automatic reg_sel_e addr_sel(input logic [11:0] addr);
    if (addr == CFG_ADDR) begin
      addr_sel = SEL_CFG;
    end else if (addr == STAT_ADDR) begin
      addr_sel = SEL_STAT;
    end else begin
      addr_sel = SEL_NONE;
    end
  endfunction

endpackage

// ### rtl/pwm_link_if.sv
// Purpose: link between the register block and one pwm decoder
// Assumes: one clock domain
// Notes:   one instance per pin
`timescale 1ns/1ns
interface pwm_link_if;
  logic       sample;
  logic       enable;
  logic [1:0] tb_code;
  logic       level;

  modport dec (input sample, input enable, input tb_code, output level);
  modport ctl (output sample, output enable, output tb_code, input level);
endinterface

// ### rtl/pwm_level_decoder.sv
// Purpose: turn a pwm waveform into a logic level
// Assumes: sample synchronous to clk
// Notes:   level is the majority of samples over one time base window
`timescale 1ns/1ns
module pwm_level_decoder
  import pin_pair_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  pwm_link_if.dec  lnk
);

  logic [10:0] cnt_q;
  logic [10:0] hi_q;
  logic        level_q;
  logic [10:0] limit;
  logic [10:0] half;
  logic [10:0] hi_sum;

  assign limit  = tb_len(lnk.tb_code) - 11'h001;
  assign half   = tb_len(lnk.tb_code) >> 1;
  assign hi_sum = hi_q + {10'h000, lnk.sample};
  assign lnk.level = level_q;

  // ---------------------------------------------------------------
  // window counter
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_q <= 11'h000;
      hi_q  <= 11'h000;
    end else if (!lnk.enable) begin
      cnt_q <= 11'h000;
      hi_q  <= 11'h000;
    end else if (cnt_q >= limit) begin
      cnt_q <= 11'h000;
      hi_q  <= 11'h000;
    end else begin
      cnt_q <= cnt_q + 11'h001;
      hi_q  <= hi_sum;
    end
  end

  // ---------------------------------------------------------------
  // decoded level
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_q <= 1'b0;
    end else if (lnk.enable && cnt_q >= limit) begin
      level_q <= (hi_sum > half);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_window_bound: assert property (
    lnk.enable && $stable(lnk.tb_code) |-> cnt_q <= limit)
    else $error("window counter past time base");
  a_window_wrap: assert property (
    lnk.enable && $stable(lnk.tb_code) && cnt_q == limit |=> cnt_q == 0)
    else $error("window did not restart at time base end");
  a_level_update: assert property (
    lnk.enable && cnt_q == limit |=> level_q == $past(hi_sum > half))
    else $error("decoded level not the window majority");

endmodule

// ### rtl/pin_pair_config.sv
// Purpose: two general pins set by one configuration register
// Assumes: axi4-lite master, one write and one read at a time
// Notes:   pins sampled on clk, output enable high while driving
//
// The register offsets and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ns
module pin_pair_config
  import pin_pair_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  pin_in,
  output logic [1:0]       pin_out,
  output logic [1:0]       pin_oe
);

  logic [14:0] cfg_q;
  logic [1:0]  sense_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic        wr_go;
  logic        rd_go;
  logic [1:0]  dec_level;
  logic [1:0]  direction;
  logic [1:0]  in_format;
  logic [1:0]  out_value;

  assign direction = cfg_q[DIR_LSB +: 2];
  assign in_format = cfg_q[FMT_LSB +: 2];
  assign out_value = cfg_q[DAT_LSB +: 2];

  // ---------------------------------------------------------------
  // write channel
  // ---------------------------------------------------------------
  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q <= CFG_RESET;
    end else if (wr_go && addr_sel(s_axi_awaddr) == SEL_CFG) begin
      // spare, time base and data bits stored as written
      if (s_axi_wstrb[0]) begin
        cfg_q[7:0] <= s_axi_wdata[7:0];
      end
      if (s_axi_wstrb[1]) begin
        cfg_q[14:8] <= s_axi_wdata[14:8];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (addr_sel(s_axi_awaddr) == SEL_CFG) ? RESP_OKAY
                                                       : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------
  assign rd_go         = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q  <= RESP_OKAY;
      if (addr_sel(s_axi_araddr) == SEL_CFG) begin
        rdata_q <= {16'h0000, CFG_TOP_BIT, cfg_q};
      end else if (addr_sel(s_axi_araddr) == SEL_STAT) begin
        rdata_q <= {30'h0000_0000, sense_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_oe  <= 2'h0;
      pin_out <= 2'h0;
    end else begin
      pin_oe  <= direction;
      pin_out <= out_value;  // static level only
    end
  end

  // ---------------------------------------------------------------
  // per pin sensing
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_pin
    pwm_link_if lnk ();

    assign lnk.sample  = pin_in[i];
    assign lnk.enable  = !direction[i] && in_format[i];
    assign lnk.tb_code = (i == 1) ? cfg_q[TB1_LSB +: 2]
                                  : cfg_q[TB0_LSB +: 2];
    assign dec_level[i] = lnk.level;

    pwm_level_decoder u_dec (
      .clk   (clk),
      .reset (reset),
      .lnk   (lnk)
    );
  end

  // ---------------------------------------------------------------
  // sensed value, one process for both bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_q <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (direction[i]) begin
          sense_q[i] <= out_value[i];
        end else if (in_format[i]) begin
          sense_q[i] <= dec_level[i];
        end else begin
          sense_q[i] <= pin_in[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_spare_no_effect: assert property (
    $stable(cfg_q[11:4]) && $stable(cfg_q[1:0])
    |=> $stable(pin_oe) && $stable(pin_out))
    else $error("spare bits changed the pins");
  a_dir_write_oe: assert property (
    wr_go && s_axi_awaddr == CFG_ADDR && s_axi_wstrb[1]
    |=> ##1 pin_oe == $past(s_axi_wdata[9:8], 2))
    else $error("direction write did not reach output enable");
  a_static_sense: assert property (
    !direction[0] && !in_format[0] |=> sense_q[0] == $past(pin_in[0]))
    else $error("static input not reported");
  a_out_static: assert property (
    pin_oe[1] && $stable(out_value) ##1 $stable(out_value)
    |-> $stable(pin_out[1]))
    else $error("output pin toggled without a data write");
  a_tb_field: assert property (
    wr_go && s_axi_awaddr == CFG_ADDR && s_axi_wstrb[0]
    |=> g_pin[1].lnk.tb_code == $past(s_axi_wdata[7:6]) &&
        g_pin[0].lnk.tb_code == $past(s_axi_wdata[5:4]))
    else $error("time base fields misplaced");
  a_out_level: assert property (
    direction[0] |=> pin_oe[0] && pin_out[0] == $past(out_value[0]))
    else $error("output level differs from data bit");
  a_input_hold: assert property (
    !direction[1] && !in_format[1] && $changed(out_value[1])
    |=> sense_q[1] == $past(pin_in[1]) && !pin_oe[1])
    else $error("data bit disturbed an input pin");
  a_top_bit_one: assert property (
    rd_go && s_axi_araddr == CFG_ADDR |=> s_axi_rvalid && s_axi_rdata[15])
    else $error("top configuration bit did not read one");
  a_cfg_write_okay: assert property (
    wr_go && s_axi_awaddr == CFG_ADDR
    |=> s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("configuration write not acknowledged");
  a_spare_high_kept: assert property (
    wr_go && s_axi_awaddr == CFG_ADDR && s_axi_wstrb[1]
    |=> cfg_q[14:12] == $past(s_axi_wdata[14:12]))
    else $error("upper spare bits not stored");
  a_spare_low_kept: assert property (
    wr_go && s_axi_awaddr == CFG_ADDR && s_axi_wstrb[0]
    |=> cfg_q[3:2] == $past(s_axi_wdata[3:2]))
    else $error("lower spare bits not stored");
  a_input_no_drive: assert property (
    !direction[0] |=> !pin_oe[0])
    else $error("input pin zero driven");
  a_static_sense_one: assert property (
    !direction[1] && !in_format[1] |=> sense_q[1] == $past(pin_in[1]))
    else $error("static input on pin one not reported");
  a_pwm_sense: assert property (
    !direction[1] && in_format[1] |=> sense_q[1] == $past(dec_level[1]))
    else $error("decoded level not reported");
  a_out_sense: assert property (
    direction[1] |=> sense_q[1] == $past(out_value[1]))
    else $error("output pin sense not its static level");
  a_out_no_decode: assert property (
    direction[0] |-> !g_pin[0].lnk.enable)
    else $error("decoder running on an output pin");
  a_static_no_decode: assert property (
    !in_format[1] |-> !g_pin[1].lnk.enable)
    else $error("decoder running with static format");
  a_out_level_one: assert property (
    direction[1] |=> pin_oe[1] && pin_out[1] == $past(out_value[1]))
    else $error("pin one level differs from data bit");

endmodule

// ### dv/pin_drive_model.sv
// Purpose: far side of the two general pins
// Assumes: mode per pin: 0 low, 1 high, 2 quarter pwm, 3 three-quarter pwm
// Notes:   device drive wins while its output enable is high
`timescale 1ns/1ns
module pin_drive_model (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [3:0] mode,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  output logic      [1:0] pin_in
);
  logic [1:0] phase_q;
  logic [1:0] ext;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_q <= 2'h0;
    end else begin
      phase_q <= phase_q + 2'h1;
    end
  end

  always_comb begin
    for (int p = 0; p < 2; p++) begin
      case (mode[2*p +: 2])
        2'h0:    ext[p] = 1'b0;
        2'h1:    ext[p] = 1'b1;
        2'h2:    ext[p] = (phase_q == 2'h0);
        default: ext[p] = (phase_q != 2'h0);
      endcase
    end
    pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
  end
endmodule

// ### dv/dual_pin_io_config_bench.sv
// Purpose: self-checking bench for the two-pin configuration block
// Assumes: axi4-lite master, fixed seed
// Notes:   pwm windows shown with quarter and three-quarter duty
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %s exp %0h got %0h", nm, e, g); end end
module dual_pin_io_config_bench
  import pin_pair_pkg::*;
;
  logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, wd, cw, seed;
  logic [3:0]  s_axi_wstrb, md;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, pin_in, pin_out, pin_oe;
  int          n_fail, compares, n;

  pin_pair_config u_pin_pair_config (
    .clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  pin_drive_model u_pin_drive_model (.clk(clk), .reset(reset), .mode(md),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

  always #50 clk = ~clk;

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(posedge clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [11:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #3000000;
    n_fail++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    {clk, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
    {s_axi_wdata, md, n_fail, compares} = 0;
    s_axi_wstrb = 4'hF;
    seed = 32'h8b63;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd_reg(CFG_ADDR);
    `CHK("cfg reset", 32'h0000_8000, rd)
    for (int i = 0; i < 12; i++) begin
      wd = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
      wr(CFG_ADDR, wd);
      `CHK("bresp", RESP_OKAY, rs)
      rd_reg(CFG_ADDR);
      `CHK("cfg", {16'h0, 1'b1, wd[14:0]}, rd)
      `CHK("oe", wd[9:8], pin_oe)
      `CHK("drive", wd[9:8] & wd[1:0], pin_out & pin_oe)
    end
    wr(12'h0F0, 32'h0);
    `CHK("bad wr", RESP_SLVERR, rs)
    rd_reg(12'h0F0);
    `CHK("bad rd", {RESP_SLVERR, 32'h0}, {rs, rd})
    rd_reg(CFG_ADDR);
    `CHK("kept", {16'h0, 1'b1, wd[14:0]}, rd)
    s_axi_wstrb <= 4'h1;
    wr(CFG_ADDR, ~wd);
    s_axi_wstrb <= 4'hF;
    rd_reg(CFG_ADDR);
    `CHK("lane", {16'h0, 1'b1, wd[14:8], ~wd[7:0]}, rd)
    for (int i = 0; i < 6; i++) begin
      wd = $random(seed);
      md <= {1'b0, wd[16], 1'b0, wd[17]};
      wr(CFG_ADDR, wd & 32'h0000_70FF);
      rd_reg(STAT_ADDR);
      `CHK("static", {wd[16], wd[17]}, rd[1:0])
      `CHK("no drive", 2'h0, pin_oe)
    end
    wd = $random(seed);
    md <= 4'hF;
    wr(CFG_ADDR, (wd & 32'h0000_70FF) | 32'h0000_0F00);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      `CHK("static out", {wd[1:0], 2'h3}, {pin_out, pin_oe})
    end
    rd_reg(STAT_ADDR);
    `CHK("out sense", wd[1:0], rd[1:0])
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        n = 16 << (2 * c);
        cw = (32'h0000_0400 << p) | (c << (4 + 2 * p));
        md <= 4'h2 << (2 * p);
        wr(CFG_ADDR, cw);
        repeat (2 * n + 8) @(posedge clk);
        rd_reg(STAT_ADDR);
        `CHK("pwm low", 1'b0, rd[p])
        wr(CFG_ADDR, 32'h0);
        md <= 4'h3 << (2 * p);
        wr(CFG_ADDR, cw);
        repeat (n / 4) @(posedge clk);
        rd_reg(STAT_ADDR);
        `CHK("pwm early", 1'b0, rd[p])
        repeat (n + 8) @(posedge clk);
        rd_reg(STAT_ADDR);
        `CHK("pwm high", 1'b1, rd[p])
      end
    end
    tally_and_finish();
  end
endmodule
